/* core/bx_pkg.sv */
// Shared constants and types for the byte-operation execute block
package bx_pkg;

    // Register byte offsets on the Wishbone bus
    localparam logic [7:0] BX_OFS_CMD    = 8'h00;
    localparam logic [7:0] BX_OFS_ACC    = 8'h04;
    localparam logic [7:0] BX_OFS_STATUS = 8'h08;
    localparam logic [7:0] BX_OFS_STACK  = 8'h0C;
    localparam logic [7:0] BX_OFS_FADDR  = 8'h10;
    localparam logic [7:0] BX_OFS_FDATA  = 8'h14;
    localparam logic [7:0] BX_OFS_WDOG   = 8'h18;
    localparam logic [7:0] BX_OFS_CTRL   = 8'h1C;

    // Command word field positions
    localparam int BX_CMD_LIT_LSB  = 0;
    localparam int BX_CMD_ADDR_LSB = 8;
    localparam int BX_CMD_DEST_BIT = 15;
    localparam int BX_CMD_OP_LSB   = 16;

    // Status and control field positions
    localparam int BX_ST_CARRY = 0;
    localparam int BX_ST_SPILL = 1;
    localparam int BX_ST_ZERO  = 2;
    localparam int BX_ST_POWERDOWN = 3;
    localparam int BX_ST_TIMEOUT   = 4;
    localparam int BX_CTRL_WAKE = 0;

    // Values after reset
    localparam logic [7:0]  BX_RST_ACC   = 8'h00;
    localparam logic        BX_RST_POWERDOWN = 1'b1;
    localparam logic        BX_RST_TIMEOUT   = 1'b1;
    localparam logic [12:0] BX_RST_PC    = 13'h0000;
    localparam logic [7:0]  BX_WDOG_ZERO = 8'h00;

    // Sizes
    localparam int BX_FILE_WORDS = 128;
    localparam int BX_STACK_DEPTH = 8;

    // Operation codes carried in the command word
    typedef enum logic [3:0] {
        OP_ROT_LEFT  = 4'b0000,
        OP_ROT_RIGHT = 4'b0001,
        OP_LIT_SUB   = 4'b0010,
        OP_REG_SUB   = 4'b0011,
        OP_NIB_SWAP  = 4'b0100,
        OP_XOR_IMM   = 4'b0101,
        OP_XOR_REG   = 4'b0110,
        OP_RETURN    = 4'b0111,
        OP_POWERDOWN = 4'b1000
    } bx_op_t;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_FETCH = 3'b001,
        ST_EXEC  = 3'b010,
        ST_RET2  = 3'b011,
        ST_SLEEP = 3'b100
    } bx_state_t;

endpackage : bx_pkg

/* core/bx_ram.sv */
// File register memory with registered read data
module bx_ram (
    // Clock
    input  wire logic       clk_i,
    // Access port
    input  wire logic [6:0] addr_i,
    input  wire logic       we_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o
);
    import bx_pkg::*;

    logic [7:0] mem [BX_FILE_WORDS];

    // Write on strobe, read data always registered
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= mem[addr_i];
    end

endmodule : bx_ram

/* core/bx_alu.sv */
// Combinational result and flag logic for the byte operations
module bx_alu (
    // Operands
    input  bx_pkg::bx_op_t op_i,
    input  wire logic [7:0] acc_i,
    input  wire logic [7:0] file_i,
    input  wire logic [7:0] lit_i,
    input  wire logic       carry_i,
    // Results
    output logic      [7:0] res_o,
    output logic            carry_o,
    output logic            spill_o,
    output logic            zero_o,
    output logic            upd_c_o,
    output logic            upd_dc_o,
    output logic            upd_z_o
);
    import bx_pkg::*;

    logic [7:0] minuend;

    // Result and which flags the operation touches
    always_comb begin
        minuend  = (op_i == OP_LIT_SUB) ? lit_i : file_i;
        res_o    = file_i;
        carry_o  = carry_i;
        spill_o  = 1'b0;
        upd_c_o  = 1'b0;
        upd_dc_o = 1'b0;
        upd_z_o  = 1'b0;
        case (op_i)
            OP_ROT_LEFT: begin
                res_o   = {file_i[6:0], carry_i};
                carry_o = file_i[7];
                upd_c_o = 1'b1;
            end
            OP_ROT_RIGHT: begin
                res_o   = {carry_i, file_i[7:1]};
                carry_o = file_i[0];
                upd_c_o = 1'b1;
            end
            OP_LIT_SUB, OP_REG_SUB: begin
                res_o    = minuend - acc_i;
                carry_o  = (minuend >= acc_i);
                spill_o  = (minuend[3:0] >= acc_i[3:0]);
                upd_c_o  = 1'b1;
                upd_dc_o = 1'b1;
                upd_z_o  = 1'b1;
            end
            OP_NIB_SWAP: begin
                res_o = {file_i[3:0], file_i[7:4]};
            end
            OP_XOR_IMM: begin
                res_o   = acc_i ^ lit_i;
                upd_z_o = 1'b1;
            end
            OP_XOR_REG: begin
                res_o   = acc_i ^ file_i;
                upd_z_o = 1'b1;
            end
            default: begin
                res_o = file_i;
            end
        endcase
        zero_o = (res_o == 8'h00);
    end

endmodule : bx_alu

/* core/bx_core.sv */
// Byte-operation execute block with Wishbone register access
// What this block does
// - Left rotate through carry: old carry into bit 0, bit 7 to carry.
// - Right rotate through carry: old carry into bit 7, bit 0 to carry.
// - Destination bit 0 writes accumulator, 1 writes the file register back.
// - Power-down clears watchdog counter and its prescaler.
// - Power-down clears powerdown status, sets timeout status, nothing else.
// - After power-down the block halts execution until woken.
// - Return pops stack into program counter, flags untouched, three busy cycles.
// - Literal minus accumulator into accumulator, updating carry, spill, zero.
// - File minus accumulator routed by destination, updating carry, spill, zero.
// - Nibble exchange routed by destination, no flag changes.
// - Accumulator xor literal into accumulator, only zero flag changes.
// - Accumulator xor file routed by destination, only zero flag changes.
//
// Local design decisions: the address map and register access over Wishbone.
module bx_core (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Status
    output logic             busy_o,
    output logic             sleep_o
);
    import bx_pkg::*;

    bx_state_t   state, next_state;
    bx_op_t      op, next_op;
    logic        dest, next_dest;
    logic [6:0]  faddr, next_faddr;
    logic [6:0]  iaddr, next_iaddr;
    logic [7:0]  lit, next_lit;
    logic [7:0]  acc, next_acc;
    logic        flag_c, next_flag_c;
    logic        flag_dc, next_flag_dc;
    logic        flag_z, next_flag_z;
    logic        powerdown_status, next_powerdown_status;
    logic        timeout_status, next_timeout_status;
    logic [7:0]  wd_cnt, next_wd_cnt;
    logic [7:0]  wd_pre, next_wd_pre;
    logic [12:0] pc, next_pc;
    logic [2:0]  sp, next_sp;
    logic        ack, next_ack;
    logic [31:0] rdat, next_rdat;
    logic [12:0] stack [BX_STACK_DEPTH];
    logic        push;
    logic [12:0] pop_val;
    logic        bus_wr;
    logic        mem_we;
    logic [6:0]  mem_addr;
    logic [7:0]  mem_wdata;
    logic [7:0]  mem_rdata;
    logic [7:0]  alu_res;
    logic        alu_c, alu_dc, alu_z;
    logic        upd_c, upd_dc, upd_z;
    logic        file_op;

    // Write lands at the edge where the master sees ack
    assign bus_wr  = wb_cyc_i & wb_stb_i & wb_we_i & ack & wb_sel_i[0];
    assign pop_val = stack[sp - 3'd1];
    assign file_op = (op == OP_ROT_LEFT) | (op == OP_ROT_RIGHT) | (op == OP_REG_SUB)
                   | (op == OP_NIB_SWAP) | (op == OP_XOR_REG);
    assign busy_o   = (state != ST_IDLE) & (state != ST_SLEEP);
    assign sleep_o  = (state == ST_SLEEP);
    assign wb_ack_o = ack;
    assign wb_dat_o = rdat;
    assign push     = bus_wr & (wb_adr_i == BX_OFS_STACK) & (state == ST_IDLE);

    // File memory port: instruction owns it while busy
    assign mem_addr  = busy_o ? iaddr : faddr;
    assign mem_we    = ((state == ST_EXEC) & file_op & dest)
                     | (bus_wr & (wb_adr_i == BX_OFS_FDATA) & (state == ST_IDLE));
    assign mem_wdata = (state == ST_EXEC) ? alu_res : wb_dat_i[7:0];

    bx_ram u_ram (
        .clk_i   (clk_i),
        .addr_i  (mem_addr),
        .we_i    (mem_we),
        .wdata_i (mem_wdata),
        .rdata_o (mem_rdata)
    );

    bx_alu u_alu (
        .op_i     (op),
        .acc_i    (acc),
        .file_i   (mem_rdata),
        .lit_i    (lit),
        .carry_i  (flag_c),
        .res_o    (alu_res),
        .carry_o  (alu_c),
        .spill_o  (alu_dc),
        .zero_o   (alu_z),
        .upd_c_o  (upd_c),
        .upd_dc_o (upd_dc),
        .upd_z_o  (upd_z)
    );

    // Return stack storage, written by bus pushes
    always_ff @(posedge clk_i) begin
        if (push) begin
            stack[sp] <= wb_dat_i[12:0];
        end
    end

    // Next-state logic for sequencer, registers and bus
    always_comb begin
        next_state            = state;
        next_op               = op;
        next_dest             = dest;
        next_faddr            = faddr;
        next_iaddr            = iaddr;
        next_lit              = lit;
        next_acc              = acc;
        next_flag_c           = flag_c;
        next_flag_dc          = flag_dc;
        next_flag_z           = flag_z;
        next_powerdown_status = powerdown_status;
        next_timeout_status   = timeout_status;
        next_pc               = pc;
        next_sp               = sp;
        next_ack              = wb_cyc_i & wb_stb_i & ~ack;
        next_rdat             = rdat;
        // Watchdog free-runs; prescaler carries into counter
        next_wd_pre           = wd_pre + 8'h01;
        next_wd_cnt           = (wd_pre == 8'hFF) ? wd_cnt + 8'h01 : wd_cnt;

        // Software writes, accepted only while idle
        if (bus_wr && state == ST_IDLE) begin
            case (wb_adr_i)
                BX_OFS_CMD: begin
                    next_lit   = wb_dat_i[BX_CMD_LIT_LSB +: 8];
                    next_iaddr = wb_dat_i[BX_CMD_ADDR_LSB +: 7];
                    next_dest  = wb_dat_i[BX_CMD_DEST_BIT];
                    next_op    = bx_op_t'(wb_dat_i[BX_CMD_OP_LSB +: 4]);
                    next_state = ST_FETCH;
                end
                BX_OFS_ACC: next_acc = wb_dat_i[7:0];
                BX_OFS_STATUS: begin
                    next_flag_c           = wb_dat_i[BX_ST_CARRY];
                    next_flag_dc          = wb_dat_i[BX_ST_SPILL];
                    next_flag_z           = wb_dat_i[BX_ST_ZERO];
                    next_powerdown_status = wb_dat_i[BX_ST_POWERDOWN];
                    next_timeout_status   = wb_dat_i[BX_ST_TIMEOUT];
                end
                BX_OFS_STACK: next_sp = sp + 3'd1;
                BX_OFS_FADDR: next_faddr = wb_dat_i[6:0];
                default: next_sp = sp;
            endcase
        end

        // Instruction sequencer
        case (state)
            ST_FETCH: next_state = ST_EXEC;
            ST_EXEC: begin
                next_state = ST_IDLE;
                if (upd_c) begin
                    next_flag_c = alu_c;
                end
                if (upd_dc) begin
                    next_flag_dc = alu_dc;
                end
                if (upd_z) begin
                    next_flag_z = alu_z;
                end
                if ((op == OP_LIT_SUB) || (op == OP_XOR_IMM) || (file_op && !dest)) begin
                    next_acc = alu_res;
                end
                if (op == OP_RETURN) begin
                    next_sp    = sp - 3'd1;
                    next_pc    = pop_val;
                    next_state = ST_RET2;
                end
                if (op == OP_POWERDOWN) begin
                    next_wd_cnt           = BX_WDOG_ZERO;
                    next_wd_pre           = BX_WDOG_ZERO;
                    next_powerdown_status = 1'b0;
                    next_timeout_status   = 1'b1;
                    next_state            = ST_SLEEP;
                end
            end
            ST_RET2: next_state = ST_IDLE;
            ST_SLEEP: begin
                // Halted until software sets the wake bit
                if (bus_wr && wb_adr_i == BX_OFS_CTRL && wb_dat_i[BX_CTRL_WAKE]) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = next_state;
        endcase

        // Read data captured together with ack
        if (wb_cyc_i && wb_stb_i && !ack && !wb_we_i) begin
            case (wb_adr_i)
                BX_OFS_CMD:    next_rdat = {29'h0, state};
                BX_OFS_ACC:    next_rdat = {24'h0, acc};
                BX_OFS_STATUS: next_rdat = {27'h0, timeout_status, powerdown_status,
                                            flag_z, flag_dc, flag_c};
                BX_OFS_STACK:  next_rdat = {16'h0, sp, pc};
                BX_OFS_FADDR:  next_rdat = {25'h0, faddr};
                BX_OFS_FDATA:  next_rdat = {24'h0, mem_rdata};
                BX_OFS_WDOG:   next_rdat = {16'h0, wd_cnt, wd_pre};
                BX_OFS_CTRL:   next_rdat = {31'h0, sleep_o};
                default:       next_rdat = 32'h0;
            endcase
        end
    end

    // State registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state            <= ST_IDLE;
            op               <= OP_ROT_LEFT;
            dest             <= 1'b0;
            faddr            <= 7'h00;
            iaddr            <= 7'h00;
            lit              <= 8'h00;
            acc              <= BX_RST_ACC;
            flag_c           <= 1'b0;
            flag_dc          <= 1'b0;
            flag_z           <= 1'b0;
            powerdown_status <= BX_RST_POWERDOWN;
            timeout_status   <= BX_RST_TIMEOUT;
            wd_cnt           <= BX_WDOG_ZERO;
            wd_pre           <= BX_WDOG_ZERO;
            pc               <= BX_RST_PC;
            sp               <= 3'h0;
            ack              <= 1'b0;
            rdat             <= 32'h0;
        end else begin
            state            <= next_state;
            op               <= next_op;
            dest             <= next_dest;
            faddr            <= next_faddr;
            iaddr            <= next_iaddr;
            lit              <= next_lit;
            acc              <= next_acc;
            flag_c           <= next_flag_c;
            flag_dc          <= next_flag_dc;
            flag_z           <= next_flag_z;
            powerdown_status <= next_powerdown_status;
            timeout_status   <= next_timeout_status;
            wd_cnt           <= next_wd_cnt;
            wd_pre           <= next_wd_pre;
            pc               <= next_pc;
            sp               <= next_sp;
            ack              <= next_ack;
            rdat             <= next_rdat;
        end
    end

    // Checks on the execute step
    sequence s_exec(bx_op_t o);
        state == ST_EXEC && op == o;
    endsequence

    a_rot_left_acc: assert property (@(posedge clk_i) disable iff (rst_i)
        s_exec(OP_ROT_LEFT) ##0 !dest |=>
        acc == {$past(mem_rdata[6:0]), $past(flag_c)} && flag_c == $past(mem_rdata[7]))
        else $error("left rotate result wrong");

    a_rot_right_acc: assert property (@(posedge clk_i) disable iff (rst_i)
        s_exec(OP_ROT_RIGHT) ##0 !dest |=>
        acc == {$past(flag_c), $past(mem_rdata[7:1])} && flag_c == $past(mem_rdata[0])
        && flag_z == $past(flag_z))
        else $error("right rotate result wrong");

    a_dest_file: assert property (@(posedge clk_i) disable iff (rst_i)
        state == ST_EXEC && file_op && dest |-> mem_we ##1 acc == $past(acc))
        else $error("file destination not honoured");

    a_sleep_wdog: assert property (@(posedge clk_i) disable iff (rst_i)
        s_exec(OP_POWERDOWN) |=> wd_cnt == 8'h00 && wd_pre == 8'h00)
        else $error("watchdog not cleared");

    a_sleep_status: assert property (@(posedge clk_i) disable iff (rst_i)
        s_exec(OP_POWERDOWN) |=> !powerdown_status && timeout_status
        && flag_c == $past(flag_c) && flag_z == $past(flag_z))
        else $error("power-down status wrong");

    a_sleep_halt: assert property (@(posedge clk_i) disable iff (rst_i)
        s_exec(OP_POWERDOWN) ##1 !bus_wr |=> state == ST_SLEEP)
        else $error("execution did not halt");

    a_return_pc: assert property (@(posedge clk_i) disable iff (rst_i)
        s_exec(OP_RETURN) |=> pc == $past(pop_val) && state == ST_RET2
        ##1 state == ST_IDLE && flag_c == $past(flag_c, 2))
        else $error("return sequence wrong");

    a_lit_sub: assert property (@(posedge clk_i) disable iff (rst_i)
        s_exec(OP_LIT_SUB) |=> acc == 8'($past(lit) - $past(acc))
        && flag_z == (acc == 8'h00))
        else $error("literal subtract wrong");

    a_sub_borrow: assert property (@(posedge clk_i) disable iff (rst_i)
        s_exec(OP_REG_SUB) |=> flag_c == ($past(mem_rdata) >= $past(acc))
        && flag_dc == ($past(mem_rdata[3:0]) >= $past(acc[3:0])))
        else $error("subtract borrow flags wrong");

    a_swap_flags: assert property (@(posedge clk_i) disable iff (rst_i)
        s_exec(OP_NIB_SWAP) |=> $stable(flag_c) && $stable(flag_dc) && $stable(flag_z))
        else $error("swap changed a flag");

    a_xor_imm: assert property (@(posedge clk_i) disable iff (rst_i)
        s_exec(OP_XOR_IMM) |=> acc == ($past(acc) ^ $past(lit)) && $stable(flag_c))
        else $error("xor immediate wrong");

    a_xor_reg: assert property (@(posedge clk_i) disable iff (rst_i)
        s_exec(OP_XOR_REG) ##0 dest |-> mem_wdata == (acc ^ mem_rdata) ##1 $stable(flag_c))
        else $error("xor register wrong");

    a_reg_sub: assert property (@(posedge clk_i) disable iff (rst_i)
        s_exec(OP_REG_SUB) ##0 !dest |=> acc == 8'($past(mem_rdata) - $past(acc)))
        else $error("register subtract wrong");

endmodule : bx_core

/* test/bx_core_tb.sv */
// Self-checking bench for the byte-operation execute block
module bx_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import bx_pkg::*;

    logic        clk_i;
    logic        rst_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        busy_o;
    logic        sleep_o;
    int          failures;
    int          num_checks;
    int          i;
    int          nb;
    logic [31:0] q;
    logic [31:0] r32;
    logic [7:0]  a;
    logic [7:0]  f;
    logic [7:0]  k;
    logic [6:0]  ad;
    logic        d;
    logic [3:0]  o;
    logic [2:0]  c3;
    logic [2:0]  sp0;
    logic [12:0] v1;
    logic [12:0] v2;
    logic [10:0] m;
    logic        toacc;

    bx_core bx_core_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o), .sleep_o(sleep_o)
    );

    // 20 MHz clock
    always #25 clk_i = ~clk_i;

    // Prints the counts and the verdict, then stops
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    // Compares one result word
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One classic Wishbone cycle, held until ack is sampled
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                       input logic [3:0] sel);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            failures++;
            $display("Error ack expected 1 seen %b", wb_ack_o);
            conclude();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        bus(1'b1, adr, dat, 4'hF);
    endtask : wr

    task automatic rd(input logic [7:0] adr);
        bus(1'b0, adr, 32'h0000_0000, 4'hF);
    endtask : rd

    // Issues a command and counts the busy cycles it takes
    task automatic exec(input logic [3:0] op, input logic dst, input logic [6:0] fa,
                        input logic [7:0] lit);
        int n;
        n = 0;
        nb = 0;
        wr(BX_OFS_CMD, {12'h000, op, dst, fa, lit});
        while (n < 20) begin
            @(negedge clk_i);
            n++;
            if (busy_o !== 1'b1) begin
                break;
            end
            nb++;
        end
        if (n >= 20) begin
            failures++;
            $display("Error busy expected 0 seen %b", busy_o);
            conclude();
        end
    endtask : exec

    // Expected {zero, spill, carry, result} of one operation
    function automatic logic [10:0] model(input logic [3:0] op, input logic [7:0] ac,
                                          input logic [7:0] fv, input logic [7:0] lv,
                                          input logic [2:0] s);
        logic [7:0] x;
        logic [7:0] r;
        logic [2:0] n;
        n = s;
        x = (op == OP_LIT_SUB) ? lv : fv;
        case (op)
            OP_ROT_LEFT: begin
                r    = {fv[6:0], s[0]};
                n[0] = fv[7];
            end
            OP_ROT_RIGHT: begin
                r    = {s[0], fv[7:1]};
                n[0] = fv[0];
            end
            OP_LIT_SUB, OP_REG_SUB: begin
                r = x - ac;
                n = {r == 8'h00, x[3:0] >= ac[3:0], x >= ac};
            end
            OP_NIB_SWAP: r = {fv[3:0], fv[7:4]};
            OP_XOR_IMM: begin
                r    = ac ^ lv;
                n[2] = (r == 8'h00);
            end
            default: begin
                r    = ac ^ fv;
                n[2] = (r == 8'h00);
            end
        endcase
        return {n, r};
    endfunction : model

    // Main sequence
    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
        failures = 0;
        num_checks = 0;
        void'($urandom(32'hF14B8333));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values, unmapped place and a write with no byte lane
        rd(BX_OFS_ACC);
        chk("acc after reset", 32'h0000_0000, q);
        rd(BX_OFS_STATUS);
        chk("status after reset", 32'h0000_0018, q);
        rd(BX_OFS_STACK);
        chk("stack after reset", 32'h0000_0000, q);
        wr(8'h20, 32'h0000_00FF);
        rd(8'h20);
        chk("unmapped", 32'h0000_0000, q);
        bus(1'b1, BX_OFS_ACC, 32'h0000_005A, 4'h0);
        rd(BX_OFS_ACC);
        chk("acc no lane", 32'h0000_0000, q);
        // Every data operation, corner operands first, then random ones
        for (i = 0; i < 56; i++) begin
            o = 4'(i % 7);
            r32 = $urandom;
            {d, ad, k, f, a} = r32;
            r32 = $urandom;
            c3 = r32[2:0];
            if (i < 14) begin
                a = {8{i >= 7}};
                f = a;
                k = a;
            end
            wr(BX_OFS_ACC, {24'h0, a});
            wr(BX_OFS_STATUS, {27'h0, 2'b11, c3});
            wr(BX_OFS_FADDR, {25'h0, ad});
            wr(BX_OFS_FDATA, {24'h0, f});
            exec(o, d, ad, k);
            chk("busy cycles", 32'd2, 32'(nb));
            m = model(o, a, f, k, c3);
            toacc = (o == OP_LIT_SUB) || (o == OP_XOR_IMM) || !d;
            rd(BX_OFS_ACC);
            chk("acc", {24'h0, toacc ? m[7:0] : a}, q);
            rd(BX_OFS_FDATA);
            chk("file", {24'h0, toacc ? f : m[7:0]}, q);
            rd(BX_OFS_STATUS);
            chk("status", {27'h0, 2'b11, m[10:8]}, q);
        end
        // An unused code runs its two busy cycles and leaves the accumulator alone
        wr(BX_OFS_ACC, 32'h0000_003C);
        exec(4'(9 + $urandom_range(6)), 1'b1, ad, 8'h5A);
        chk("nop cycles", 32'd2, 32'(nb));
        rd(BX_OFS_ACC);
        chk("acc nop", 32'h0000_003C, q);
        // Two nested returns come back in reverse order, flags untouched
        wr(BX_OFS_STATUS, 32'h0000_001D);
        rd(BX_OFS_STACK);
        sp0 = q[15:13];
        r32 = $urandom;
        {v2, v1} = r32[25:0];
        wr(BX_OFS_STACK, {19'h0, v1});
        wr(BX_OFS_STACK, {19'h0, v2});
        exec(OP_RETURN, 1'b0, 7'h00, 8'h00);
        chk("return cycles", 32'd3, 32'(nb));
        rd(BX_OFS_STACK);
        chk("stack pop", {16'h0, sp0 + 3'd1, v2}, q);
        exec(OP_RETURN, 1'b0, 7'h00, 8'h00);
        rd(BX_OFS_STACK);
        chk("stack pop", {16'h0, sp0, v1}, q);
        rd(BX_OFS_STATUS);
        chk("status return", 32'h0000_001D, q);
        // Power-down clears the watchdog and powerdown status, sets timeout status, then halts
        rd(BX_OFS_WDOG);
        chk("watchdog running", 32'd1, 32'(q[15:8] != 8'h00));
        rd(BX_OFS_ACC);
        a = q[7:0];
        wr(BX_OFS_STATUS, 32'h0000_000E);
        exec(OP_POWERDOWN, 1'b0, 7'h00, 8'h00);
        chk("sleep", 32'd1, {31'h0, sleep_o});
        rd(BX_OFS_WDOG);
        chk("watchdog counter", 32'h0000_0000, {24'h0, q[15:8]});
        chk("prescaler low", 32'd1, 32'(q[7:0] < 8'h10));
        rd(BX_OFS_STATUS);
        chk("status sleep", 32'h0000_0016, q);
        wr(BX_OFS_CMD, {12'h000, 4'(OP_XOR_IMM), 8'h00, 8'hFF});
        repeat (4) @(negedge clk_i);
        chk("busy asleep", 32'd0, {31'h0, busy_o});
        rd(BX_OFS_CTRL);
        chk("ctrl asleep", 32'h0000_0001, q);
        wr(BX_OFS_CTRL, 32'h0000_0001);
        rd(BX_OFS_CTRL);
        chk("ctrl woken", 32'h0000_0000, q);
        rd(BX_OFS_ACC);
        chk("acc asleep", {24'h0, a}, q);
        exec(OP_XOR_IMM, 1'b0, 7'h00, 8'hFF);
        rd(BX_OFS_ACC);
        chk("acc woken", {24'h0, ~a}, q);
        conclude();
    end

endmodule : bx_core_tb
